// file: logic/pcf_cfg.svh
// register offsets, field positions, reset values and frame layout of the codec
`ifndef PCF_CFG_SVH
`define PCF_CFG_SVH
// ****************************************
// register byte offsets
// ****************************************
`define PCF_OFF_CTRL 8'h00
`define PCF_OFF_IDS 8'h04
`define PCF_OFF_OFFS 8'h08
`define PCF_OFF_UDST 8'h0C
`define PCF_OFF_UPUSH 8'h10
`define PCF_OFF_UGO 8'h14
`define PCF_OFF_UPOP 8'h18
`define PCF_OFF_STAT 8'h1C
`define PCF_OFF_RXHDR 8'h20
`define PCF_OFF_RXD0 8'h24
`define PCF_OFF_RXD1 8'h28
`define PCF_OFF_RXD2 8'h2C
`define PCF_OFF_TXCMD 8'h30
`define PCF_OFF_TXD0 8'h34
`define PCF_OFF_TXD1 8'h38
`define PCF_OFF_TXD2 8'h3C
// ****************************************
// control field positions
// ****************************************
`define PCF_CTRL_FRAME 0
`define PCF_CTRL_PPS 1
`define PCF_CTRL_ALT 2
`define PCF_CTRL_TODSEL 3
`define PCF_CTRL_ASYNC 5
`define PCF_CTRL_RXPPS 6
`define PCF_CTRL_TXSYNC 7
`define PCF_CTRL_RXSYNC 10
`define PCF_CTRL_RXTOD 13
`define PCF_CTRL_RXSYNCEN 15
`define PCF_CTRL_MASTER 16
`define PCF_CTRL_MASK 32'h0001FFFF
// ****************************************
// reset values
// ****************************************
`define PCF_CTRL_RST 32'h00000000
`define PCF_IDS_RST 32'h00000000
`define PCF_OFFS_RST 32'h00000000
`define PCF_UDST_RST 32'h00000000
// ****************************************
// frame layout
// ****************************************
`define PCF_FRAME_BITS 112
`define PCF_UBYTES_MAX 9
`define PCF_BLOCK_MAX 128
`endif

// file: logic/pcf_pkg.sv
// types shared by the carrier frame codec
package pcf_pkg;
  // ****************************************
  // command codes, symbols and states
  // ****************************************
  typedef enum logic [2:0] {
    CMD_PPS = 3'h0, CMD_USER = 3'h1, CMD_READ = 3'h2, CMD_SYNC = 3'h3, CMD_WRITE = 3'h4
  } pcf_cmd_t;
  typedef enum logic [2:0] {SYM_SPACE = 3'h1, SYM_ZERO = 3'h2, SYM_ONE = 3'h4} pcf_sym_t;
  typedef enum logic [1:0] {RX_IDLE = 2'h1, RX_BITS = 2'h2} pcf_rxst_t;
  typedef enum logic [1:0] {UG_IDLE = 2'h1, UG_READ = 2'h2} pcf_ugst_t;
endpackage : pcf_pkg

// file: logic/pcf_byte_ram.sv
// byte queue storage with registered read data
module pcf_byte_ram
  import pcf_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [W-1:0] wd,
  input wire logic [AW-1:0] ra,
  output logic [W-1:0] rd
);
  logic [W-1:0] mem [D];
  // size check
  if (D != (1 << AW)) begin : gBad
    $error("depth must be two to the address width");
  end
  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end
  // read port, one cycle behind the address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd <= '0;
    end else begin
      rd <= mem[ra];
    end
  end
endmodule : pcf_byte_ram

// file: logic/pcf_codec.sv
// pulse-width carrier frame encoder and decoder with wishbone registers
`include "pcf_cfg.svh"
module pcf_codec
  import pcf_pkg::*;
#(
  parameter int QDEPTH = 128,
  parameter int QAW = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic txCarrier,
  output logic pwmTx,
  input wire logic rxPwm,
  input wire logic [3:0] ppsIn,
  input wire logic altPpsIn,
  input wire logic [87:0] todIn,
  output logic [1:0] todSrcSel,
  input wire logic syncIn,
  input wire logic [87:0] syncData,
  output logic [2:0] syncSrcSel,
  output logic rxPpsPulse,
  output logic rxTodLoad,
  output logic [1:0] rxTodSel,
  output logic rxSyncLoad,
  output logic [2:0] rxSyncSel,
  output logic [87:0] rxPayload,
  output logic remReq,
  output logic remWe,
  output logic [15:0] remAddr,
  output logic [71:0] remWdata,
  input wire logic [71:0] remRdata,
  input wire logic remAck
);
  if (QDEPTH != `PCF_BLOCK_MAX || QAW < 7) begin : gBad
    $error("queue must hold one whole block");
  end

  // frame builder: header, payload, even parity over the whole frame
  function automatic logic [111:0] mkFrame(input logic [2:0] cmd, input logic [7:0] src,
    input logic bc, input logic [7:0] dst, input logic [87:0] pay);
    logic [110:0] body;
    body = {cmd, src, bc, dst, 3'h0, pay};
    mkFrame = {body, ^body};
  endfunction : mkFrame

  // byte-lane write merge
  function automatic logic [31:0] wmrg(input logic [31:0] old, input logic [31:0] dat,
    input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wmrg = (old & ~m) | (dat & m);
  endfunction : wmrg

  // ****************************************
  // register bus
  // ****************************************
  logic ackFf;
  logic [31:0] ctrlFf, idsFf, offsFf, udstFf, txcmdFf, txd0Ff, txd1Ff, txd2Ff;
  logic [31:0] datFf;
  logic [7:0] parErrFf;
  logic rxNewFf;
  logic [2:0] rxCmdFf;
  logic [7:0] rxSrcFf;
  logic [87:0] rxPayFf;
  logic [QAW:0] txCntFf, rxCntFf;
  logic [7:0] blkLeftFf;
  logic [6:0] txLeftFf;
  logic [7:0] rxByte;
  wire wbReq = wb_cyc_i & wb_stb_i & ~ackFf;
  wire wbWr = wbReq & wb_we_i;
  wire wbRd = wbReq & ~wb_we_i;
  wire [7:0] a = wb_adr_i;
  // address decode
  wire hCtrl = a == `PCF_OFF_CTRL;
  wire hIds = a == `PCF_OFF_IDS;
  wire hOffs = a == `PCF_OFF_OFFS;
  wire hUdst = a == `PCF_OFF_UDST;
  wire hTxcmd = a == `PCF_OFF_TXCMD;
  wire hTxd0 = a == `PCF_OFF_TXD0;
  wire hTxd1 = a == `PCF_OFF_TXD1;
  wire hTxd2 = a == `PCF_OFF_TXD2;
  wire upush = wbWr & (a == `PCF_OFF_UPUSH) & wb_sel_i[0] & (txCntFf < QDEPTH);
  wire ugo = wbWr & (a == `PCF_OFF_UGO) & (blkLeftFf == 8'h00);
  wire upop = wbRd & (a == `PCF_OFF_UPOP) & (rxCntFf != '0);
  wire hdrRd = wbRd & (a == `PCF_OFF_RXHDR);
  wire swArm = wbWr & hTxcmd;
  wire [7:0] encId = idsFf[7:0];
  wire [7:0] decId = idsFf[15:8];
  wire master = ctrlFf[`PCF_CTRL_MASTER];
  wire frameEn = ctrlFf[`PCF_CTRL_FRAME];
  wire [31:0] stat = {parErrFf, rxCntFf[7:0], txCntFf[7:0], 6'h00,
                      blkLeftFf != 8'h00, txLeftFf != 7'h00};
  wire [31:0] rdMux =
    hCtrl ? ctrlFf :
    hIds ? idsFf :
    hOffs ? offsFf :
    hUdst ? udstFf :
    (a == `PCF_OFF_UPOP) ? {23'h0, rxCntFf != '0, rxByte} :
    (a == `PCF_OFF_STAT) ? stat :
    (a == `PCF_OFF_RXHDR) ? {15'h0, rxNewFf, rxSrcFf, 5'h00, rxCmdFf} :
    (a == `PCF_OFF_RXD0) ? rxPayFf[87:56] :
    (a == `PCF_OFF_RXD1) ? rxPayFf[55:24] :
    (a == `PCF_OFF_RXD2) ? {8'h00, rxPayFf[23:0]} :
    hTxcmd ? txcmdFf :
    hTxd0 ? txd0Ff :
    hTxd1 ? txd1Ff :
    hTxd2 ? txd2Ff : 32'h0;
  // bus registers; an unmapped address is acked and reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ackFf <= 1'b0;
      datFf <= 32'h0;
      ctrlFf <= `PCF_CTRL_RST;
      idsFf <= `PCF_IDS_RST;
      offsFf <= `PCF_OFFS_RST;
      udstFf <= `PCF_UDST_RST;
      txcmdFf <= 32'h0;
      txd0Ff <= 32'h0;
      txd1Ff <= 32'h0;
      txd2Ff <= 32'h0;
    end else begin
      ackFf <= wbReq;
      if (wbRd) datFf <= rdMux;
      if (wbWr && hCtrl) ctrlFf <= wmrg(ctrlFf, wb_dat_i, wb_sel_i) & `PCF_CTRL_MASK;
      if (wbWr && hIds) idsFf <= wmrg(idsFf, wb_dat_i, wb_sel_i) & 32'h0000FFFF;
      if (wbWr && hOffs) offsFf <= wmrg(offsFf, wb_dat_i, wb_sel_i);
      if (wbWr && hUdst) udstFf <= wmrg(udstFf, wb_dat_i, wb_sel_i) & 32'h000001FF;
      if (swArm) txcmdFf <= wmrg(txcmdFf, wb_dat_i, wb_sel_i) & 32'h0001FF07;
      if (wbWr && hTxd0) txd0Ff <= wmrg(txd0Ff, wb_dat_i, wb_sel_i);
      if (wbWr && hTxd1) txd1Ff <= wmrg(txd1Ff, wb_dat_i, wb_sel_i);
      if (wbWr && hTxd2) txd2Ff <= wmrg(txd2Ff, wb_dat_i, wb_sel_i) & 32'h00FFFFFF;
    end
  end
  assign wb_ack_o = ackFf;
  assign wb_dat_o = datFf;
  assign todSrcSel = ctrlFf[`PCF_CTRL_TODSEL+:2];
  assign syncSrcSel = ctrlFf[`PCF_CTRL_TXSYNC+:3];
  assign rxTodSel = ctrlFf[`PCF_CTRL_RXTOD+:2];
  assign rxSyncSel = ctrlFf[`PCF_CTRL_RXSYNC+:3];

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  logic [2:0] cSyncFf, rSyncFf;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cSyncFf <= 3'h0;
      rSyncFf <= 3'h0;
    end else begin
      cSyncFf <= {cSyncFf[1:0], txCarrier};
      rSyncFf <= {rSyncFf[1:0], rxPwm};
    end
  end
  wire tRise = cSyncFf[1] & ~cSyncFf[2];
  wire rRise = rSyncFf[1] & ~rSyncFf[2];
  wire rFall = ~rSyncFf[1] & rSyncFf[2];

  // ****************************************
  // transmit request sources and arbiter
  // ****************************************
  logic ppsPendFf, repPendFf, syncPendFf, swPendFf, usrPendFf, firstFf, repIsWrFf;
  logic [87:0] ppsPayFf, syncPayFf, repPayFf, usrPayFf;
  logic [7:0] repDstFf;
  logic [111:0] txShFf;
  wire txIdle = txLeftFf == 7'h00;
  wire ppsSrc = ctrlFf[`PCF_CTRL_ALT] ? altPpsIn : ppsIn[todSrcSel];
  wire ppsEvt = ppsSrc & frameEn & ctrlFf[`PCF_CTRL_PPS];
  wire syncEvt = syncIn & frameEn;
  wire [87:0] todAdj = ctrlFf[`PCF_CTRL_ASYNC] ? todIn + {56'h0, offsFf} : todIn;
  wire goPps = txIdle & ppsPendFf;
  wire goRep = txIdle & ~ppsPendFf & repPendFf;
  wire goSync = txIdle & ~ppsPendFf & ~repPendFf & syncPendFf;
  wire goSw = txIdle & ~ppsPendFf & ~repPendFf & ~syncPendFf & swPendFf;
  wire goUsr = txIdle & ~ppsPendFf & ~repPendFf & ~syncPendFf & ~swPendFf & usrPendFf;
  wire uBc = udstFf[8] & master;
  wire [111:0] txFrame =
    goPps ? mkFrame(CMD_PPS, encId, uBc, udstFf[7:0], ppsPayFf) :
    goRep ? mkFrame(repIsWrFf ? CMD_WRITE : CMD_READ, encId, 1'b0, repDstFf, repPayFf) :
    goSync ? mkFrame(CMD_SYNC, encId, uBc, udstFf[7:0], syncPayFf) :
    goSw ? mkFrame(txcmdFf[2:0], encId, txcmdFf[16] & master, txcmdFf[15:8],
                   {txd0Ff, txd1Ff, txd2Ff[23:0]}) :
    mkFrame(CMD_USER, encId, uBc, udstFf[7:0], usrPayFf);
  wire txGo = goPps | goRep | goSync | goSw | goUsr;
  // pending flags; a new event wins over the send that clears it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ppsPendFf <= 1'b0;
      syncPendFf <= 1'b0;
      swPendFf <= 1'b0;
      ppsPayFf <= 88'h0;
      syncPayFf <= 88'h0;
    end else begin
      ppsPendFf <= ppsEvt | (ppsPendFf & ~goPps);
      syncPendFf <= syncEvt | (syncPendFf & ~goSync);
      swPendFf <= (swArm & frameEn) | (swPendFf & ~goSw);
      if (ppsEvt) ppsPayFf <= todAdj;
      if (syncEvt) syncPayFf <= syncData;
    end
  end

  // ****************************************
  // symbol modulator on the carrier
  // ****************************************
  logic [15:0] tCntFf, tPerFf;
  pcf_sym_t curSymFf;
  wire [15:0] tInc = tCntFf + 16'h0001;
  wire [15:0] thrZ = tPerFf >> 2;
  wire [15:0] thrS = tPerFf >> 1;
  wire [15:0] thrO = thrS + thrZ;
  wire [15:0] tThr = curSymFf == SYM_ZERO ? thrZ : curSymFf == SYM_ONE ? thrO : thrS;
  wire pcf_sym_t nxtSym = pcf_sym_t'(txLeftFf > 7'h01 ? (txShFf[111] ? SYM_ONE : SYM_ZERO) :
    SYM_SPACE);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tCntFf <= 16'h0;
      tPerFf <= 16'h0;
      curSymFf <= SYM_SPACE;
      txShFf <= 112'h0;
      txLeftFf <= 7'h00;
      pwmTx <= 1'b0;
    end else begin
      tCntFf <= tRise ? 16'h0 : tInc;
      if (tRise) tPerFf <= tInc;
      pwmTx <= tRise ? 1'b1 : (tInc == tThr ? 1'b0 : pwmTx);
      if (tRise) curSymFf <= nxtSym;
      if (tRise && !txIdle) begin
        txShFf <= {txShFf[110:0], 1'b0};
        txLeftFf <= txLeftFf - 7'h01;
      end else if (txGo) begin
        txShFf <= txFrame;
        txLeftFf <= 7'd113; // frame plus one trailing space
      end
    end
  end

  // ****************************************
  // symbol demodulator and frame capture
  // ****************************************
  logic [15:0] rCntFf, rHiFf;
  logic rSeenFf, rxDoneFf;
  pcf_rxst_t rxStFf;
  logic [6:0] rxCntFf7;
  logic [111:0] rxShFf;
  wire [15:0] rInc = rCntFf + 16'h0001;
  wire [18:0] hi8 = {rHiFf, 3'h0};
  wire [18:0] per1 = {3'h0, rInc};
  wire [18:0] per3 = (per1 << 1) + per1;
  wire [18:0] per5 = (per1 << 2) + per1;
  wire symStb = rRise & rSeenFf;
  wire symZero = hi8 < per3;
  wire symOne = hi8 > per5;
  wire symBit = symOne;
  wire symData = symZero | symOne;
  wire lastBit = rxStFf == RX_BITS && rxCntFf7 == 7'd111;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rCntFf <= 16'h0;
      rHiFf <= 16'h0;
      rSeenFf <= 1'b0;
      rxStFf <= RX_IDLE;
      rxCntFf7 <= 7'h00;
      rxShFf <= 112'h0;
      rxDoneFf <= 1'b0;
    end else begin
      rCntFf <= rRise ? 16'h0 : rInc;
      if (rFall) rHiFf <= rInc;
      if (rRise) rSeenFf <= 1'b1;
      rxDoneFf <= symStb & symData & lastBit;
      if (symStb) begin
        case (rxStFf)
          RX_IDLE: begin
            if (symData) begin
              rxShFf <= {rxShFf[110:0], symBit};
              rxCntFf7 <= 7'h01;
              rxStFf <= RX_BITS;
            end
          end
          RX_BITS: begin
            if (!symData || lastBit) begin
              rxStFf <= RX_IDLE; // a space inside a frame aborts it
            end
            if (symData) begin
              rxShFf <= {rxShFf[110:0], symBit};
              rxCntFf7 <= rxCntFf7 + 7'h01;
            end
          end
          default: rxStFf <= RX_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // frame check and dispatch
  // ****************************************
  wire [2:0] fCmd = rxShFf[111:109];
  wire [7:0] fSrc = rxShFf[108:101];
  wire fBc = rxShFf[100];
  wire [7:0] fDst = rxShFf[99:92];
  wire [87:0] fPay = rxShFf[88:1];
  wire parOk = ~^rxShFf;
  wire accept = rxDoneFf & parOk & (fBc | fDst == decId);
  wire isRem = accept & (fCmd == CMD_READ || fCmd == CMD_WRITE);
  wire remStart = isRem & ~master & ~remReq;
  wire usrFrm = accept & fCmd == CMD_USER;
  logic [3:0] pushCntFf;
  logic [71:0] pushShFf;
  logic [15:0] remAddrFf;
  logic [7:0] remDstFf;
  wire rxPush = (pushCntFf != 4'h0) & (rxCntFf < QDEPTH);
  wire [3:0] fLen = fPay[79:72] > 8'd9 ? 4'd9 : fPay[75:72];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxPpsPulse <= 1'b0;
      rxTodLoad <= 1'b0;
      rxSyncLoad <= 1'b0;
      rxPayload <= 88'h0;
      rxPayFf <= 88'h0;
      rxCmdFf <= 3'h0;
      rxSrcFf <= 8'h0;
      rxNewFf <= 1'b0;
      parErrFf <= 8'h0;
      pushCntFf <= 4'h0;
      pushShFf <= 72'h0;
    end else begin
      rxPpsPulse <= accept & fCmd == CMD_PPS & ctrlFf[`PCF_CTRL_RXPPS];
      rxTodLoad <= accept & fCmd == CMD_PPS;
      rxSyncLoad <= accept & fCmd == CMD_SYNC & ctrlFf[`PCF_CTRL_RXSYNCEN];
      // payload moves only together with a load pulse
      if (accept && (fCmd == CMD_PPS || fCmd == CMD_SYNC && ctrlFf[`PCF_CTRL_RXSYNCEN])) begin
        rxPayload <= fPay;
      end
      if (accept) begin
        rxPayFf <= fPay;
        rxCmdFf <= fCmd;
        rxSrcFf <= fSrc;
      end
      rxNewFf <= accept | (rxNewFf & ~hdrRd);
      if (rxDoneFf && !parOk && parErrFf != 8'hFF) parErrFf <= parErrFf + 8'h01;
      // user bytes go to the receive queue; nothing is sent back
      if (usrFrm && fLen != 4'h0) begin
        pushCntFf <= fLen;
        pushShFf <= fPay[71:0];
      end else if (pushCntFf != 4'h0) begin
        pushCntFf <= pushCntFf - 4'h1;
        pushShFf <= {pushShFf[63:0], 8'h00};
      end
    end
  end

  // ****************************************
  // remote register access and reply
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remReq <= 1'b0;
      remWe <= 1'b0;
      remAddrFf <= 16'h0;
      remWdata <= 72'h0;
      remDstFf <= 8'h0;
      repPendFf <= 1'b0;
      repIsWrFf <= 1'b0;
      repPayFf <= 88'h0;
      repDstFf <= 8'h0;
    end else begin
      if (remStart) begin
        remReq <= 1'b1;
        remWe <= fCmd == CMD_WRITE;
        remAddrFf <= fPay[87:72];
        remWdata <= fPay[71:0];
        remDstFf <= fSrc;
      end else if (remReq && remAck) begin
        remReq <= 1'b0;
      end
      repPendFf <= (remReq & remAck) | (repPendFf & ~goRep);
      if (remReq && remAck) begin
        repIsWrFf <= remWe;
        repPayFf <= {remAddrFf, remWe ? 72'h0 : remRdata};
        repDstFf <= remDstFf;
      end
    end
  end
  assign remAddr = remAddrFf;

  // ****************************************
  // user block gather from the transmit queue
  // ****************************************
  logic [QAW-1:0] txWpFf, txRpFf, rxWpFf, rxRpFf;
  logic [7:0] txRd;
  pcf_ugst_t ugStFf;
  logic ugPhFf;
  logic [3:0] ugNFf, ugIdxFf;
  logic [71:0] ugDatFf;
  wire [3:0] ugN = blkLeftFf > 8'd9 ? 4'd9 : blkLeftFf[3:0];
  wire ugStart = ugStFf == UG_IDLE && blkLeftFf != 8'h00 && !usrPendFf;
  wire txPop = ugStFf == UG_READ && ugPhFf;
  wire ugLast = txPop && ugIdxFf + 4'h1 == ugNFf;
  wire [QAW:0] blkAvail = txCntFf > QDEPTH ? (QAW+1)'(QDEPTH) : txCntFf;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ugStFf <= UG_IDLE;
      ugPhFf <= 1'b0;
      ugNFf <= 4'h0;
      ugIdxFf <= 4'h0;
      ugDatFf <= 72'h0;
      blkLeftFf <= 8'h00;
      firstFf <= 1'b0;
      usrPendFf <= 1'b0;
      usrPayFf <= 88'h0;
    end else begin
      usrPendFf <= (ugLast & frameEn) | (usrPendFf & ~goUsr);
      if (ugo) begin
        blkLeftFf <= 8'(blkAvail);
        firstFf <= 1'b1;
      end else if (ugStart) begin
        blkLeftFf <= blkLeftFf - {4'h0, ugN};
      end
      if (goUsr) firstFf <= 1'b0;
      case (ugStFf)
        UG_IDLE: begin
          if (ugStart) begin
            ugNFf <= ugN;
            ugIdxFf <= 4'h0;
            ugPhFf <= 1'b0;
            ugDatFf <= 72'h0;
            ugStFf <= UG_READ;
          end
        end
        UG_READ: begin
          ugPhFf <= ~ugPhFf;
          if (txPop) begin
            ugDatFf[71 - 8 * ugIdxFf -: 8] <= txRd;
            ugIdxFf <= ugIdxFf + 4'h1;
          end
          if (ugLast) ugStFf <= UG_IDLE;
        end
        default: ugStFf <= UG_IDLE;
      endcase
      if (ugLast) begin
        usrPayFf <= {firstFf, blkLeftFf[6:0], 4'h0, ugNFf, ugDatFf};
        usrPayFf[71 - 8 * ugIdxFf -: 8] <= txRd;
      end
    end
  end

  // ****************************************
  // queue pointers and storage
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txWpFf <= '0;
      txRpFf <= '0;
      rxWpFf <= '0;
      rxRpFf <= '0;
      txCntFf <= '0;
      rxCntFf <= '0;
    end else begin
      if (upush) txWpFf <= txWpFf + 1'b1;
      if (txPop) txRpFf <= txRpFf + 1'b1;
      if (rxPush) rxWpFf <= rxWpFf + 1'b1;
      if (upop) rxRpFf <= rxRpFf + 1'b1;
      txCntFf <= txCntFf + {{QAW{1'b0}}, upush} - {{QAW{1'b0}}, txPop};
      rxCntFf <= rxCntFf + {{QAW{1'b0}}, rxPush} - {{QAW{1'b0}}, upop};
    end
  end
  pcf_byte_ram #(.W(8), .D(QDEPTH), .AW(QAW)) uTxQ (
    .clk(clk), .nrst(nrst), .we(upush), .wa(txWpFf), .wd(wb_dat_i[7:0]),
    .ra(txRpFf), .rd(txRd)
  );
  pcf_byte_ram #(.W(8), .D(QDEPTH), .AW(QAW)) uRxQ (
    .clk(clk), .nrst(nrst), .we(rxPush), .wa(rxWpFf), .wd(pushShFf[71:64]),
    .ra(rxRpFf), .rd(rxByte)
  );
endmodule : pcf_codec

// file: bench/pcf_far_end.sv
// far end: free-running carrier and a line looping the modulated carrier back
module pcf_far_end (
  output logic txCarrier,
  input wire logic pwmTx,
  output logic rxPwm
);
  timeunit 1ns;
  timeprecision 1ns;
  // carrier at 80 ns, toggled every 40 ns
  initial begin
    txCarrier = 1'b0;
    forever #40 txCarrier = ~txCarrier;
  end
  assign #3 rxPwm = pwmTx;
endmodule : pcf_far_end

// file: bench/pcf_codec_properties.sv
// port timing checks of the carrier frame codec
module pcf_codec_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic txCarrier,
  input wire logic pwmTx,
  input wire logic rxPpsPulse,
  input wire logic rxTodLoad,
  input wire logic rxSyncLoad,
  input wire logic [87:0] rxPayload,
  input wire logic remReq,
  input wire logic remWe,
  input wire logic [15:0] remAddr,
  input wire logic remAck
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // bus request and its one-cycle answer
  sequence reqS; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ackS; wb_ack_o ##1 !wb_ack_o; endsequence
  bus_ack_once_a: assert property (reqS |=> ackS) else $error("bad ack");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  pps_with_tod_a:
    assert property (rxPpsPulse |-> rxTodLoad) else $error("lone pps");
  one_load_a: assert property (!(rxTodLoad && rxSyncLoad)) else $error("two loads");
  payload_hold_a:
    assert property (!rxTodLoad && !rxSyncLoad |-> $stable(rxPayload)) else $error("moved");
  req_held_a:
    assert property (remReq && !remAck |=> remReq && $stable({remWe, remAddr}))
    else $error("req lost");
  req_release_a: assert property (remReq && remAck |=> !remReq) else $error("stuck");
  carrier_rise_a:
    assert property ($rose(txCarrier) |-> ##[1:5] pwmTx) else $error("no rise");
endmodule : pcf_codec_properties
bind pcf_codec pcf_codec_properties u_pcf_codec_properties (.*);

// file: bench/tb.sv
// loop-back bench of the carrier frame codec over its register bus
`include "pcf_cfg.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, txCarrier, pwmTx, rxPwm, ok;
  logic altPpsIn, syncIn, rxPpsPulse, rxTodLoad, rxSyncLoad, remReq, remWe, remAck;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, ppsIn;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [87:0] todIn, syncData, rxPayload;
  logic [1:0] todSrcSel, rxTodSel;
  logic [2:0] syncSrcSel, rxSyncSel, ev;
  logic [15:0] remAddr;
  logic [71:0] remWdata, remRdata;
  int errors, n_compared;
  localparam logic [87:0] PAY = {32'h12345678, 32'h9ABCDEF0, 24'h112233};
  localparam logic [87:0] TOD = 88'hC30123456789ABCDEF0011;
  localparam logic [7:0] RA [4] = '{8'h00, 8'h04, 8'h0C, 8'h40};
  localparam logic [7:0] UB [3] = '{8'hA1, 8'hB2, 8'hC3};
  assign ev = {remReq, rxSyncLoad, rxTodLoad};
  pcf_codec u_pcf_codec (.*);
  pcf_far_end u_pcf_far_end (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // one classic cycle, held until ack is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      stop_test();
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus
  // bounded wait for an event; ok tells whether it came
  task automatic waitp(input int k, input int lim);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge clk);
      ok = ev[k];
    end
  endtask : waitp
  task automatic frame(input logic [31:0] c, input int k, input int lim);
    bus(1'b1, `PCF_OFF_TXCMD, c);
    waitp(k, lim);
  endtask : frame
  task automatic reply();
    @(posedge clk);
    remAck <= 1'b1;
    @(posedge clk);
    remAck <= 1'b0;
  endtask : reply
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, remAck, altPpsIn, syncIn, nrst} = '0;
    {wb_adr_i, wb_dat_i, ppsIn, todIn, syncData, remRdata} = '0;
    wb_sel_i = 4'hF;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    foreach (RA[i]) begin
      bus(1'b0, RA[i], 32'h0);
      `CHK("reset reg", 32'h0, q)
    end
    bus(1'b0, `PCF_OFF_UPOP, 32'h0);
    `CHK("empty pop", 32'h0, q & 32'h100)
    bus(1'b1, `PCF_OFF_IDS, 32'h00005A3C);
    bus(1'b1, `PCF_OFF_UDST, 32'h0000005A);
    bus(1'b1, `PCF_OFF_CTRL, 32'h0000AED3);
    bus(1'b0, `PCF_OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h0000AED3, q)
    `CHK("selects", 10'h2AD, {todSrcSel, syncSrcSel, rxSyncSel, rxTodSel})
    // pps from the third accumulator crosses the loop with its time
    todIn <= TOD;
    ppsIn <= 4'h4;
    @(posedge clk);
    ppsIn <= 4'h0;
    waitp(0, 2000);
    `CHK("pps pulse", 1'b1, rxPpsPulse)
    `CHK("tod", TOD, rxPayload)
    // async mode adds the offset to the time sent
    bus(1'b1, `PCF_OFF_OFFS, 32'h00000010);
    bus(1'b1, `PCF_OFF_CTRL, 32'h0000AEF3);
    ppsIn <= 4'h4;
    @(posedge clk);
    ppsIn <= 4'h0;
    waitp(0, 2000);
    `CHK("async tod", 88'hC30123456789ABCDEF0021, rxPayload)
    // software sync frame to our own decoder
    bus(1'b1, `PCF_OFF_TXD0, 32'h12345678);
    bus(1'b1, `PCF_OFF_TXD1, 32'h9ABCDEF0);
    bus(1'b1, `PCF_OFF_TXD2, 32'h00112233);
    frame(32'h00005A03, 1, 2000);
    `CHK("sync data", PAY, rxPayload)
    bus(1'b0, `PCF_OFF_RXHDR, 32'h0);
    `CHK("header", 32'h00013C03, q & 32'h0001FF07)
    bus(1'b0, `PCF_OFF_RXD0, 32'h0);
    `CHK("rx bytes", 32'h12345678, q)
    // other destination dropped, master broadcast taken
    frame(32'h00007703, 1, 1500);
    `CHK("other dst", 1'b0, ok)
    bus(1'b1, `PCF_OFF_CTRL, 32'h0001AED3);
    frame(32'h00017703, 1, 2000);
    `CHK("broadcast", 1'b1, ok)
    // three user bytes loop back into the receive queue
    foreach (UB[i]) bus(1'b1, `PCF_OFF_UPUSH, {24'h0, UB[i]});
    bus(1'b1, `PCF_OFF_UGO, 32'h0);
    for (int i = 0; i < 500 && q[23:16] != 8'h03; i++) bus(1'b0, `PCF_OFF_STAT, 32'h0);
    `CHK("rx count", 8'h03, q[23:16])
    bus(1'b0, `PCF_OFF_RXD0, 32'h0);
    `CHK("user head", 32'h8003A1B2, q)
    foreach (UB[i]) begin
      bus(1'b0, `PCF_OFF_UPOP, 32'h0);
      `CHK("user byte", {1'b1, UB[i]}, q[8:0])
    end
    // remote read then write at a non-master
    bus(1'b1, `PCF_OFF_CTRL, 32'h0000AED3);
    frame(32'h00005A02, 2, 2000);
    `CHK("read req", 17'h01234, {remWe, remAddr})
    reply();
    frame(32'h00005A04, 2, 3000);
    `CHK("write req", {1'b1, 16'h1234, PAY[71:0]}, {remWe, remAddr, remWdata})
    reply();
    stop_test();
  end
endmodule : tb
